/* bench/srcsc_properties.sv */
// Concurrent checks on the reset and clock source controller's top ports.
// Assumes a bind to srcsc_top; every check runs on clk and idles under reset_n.
`timescale 1ns/1ps
module srcsc_properties
   import srcsc_pkg::*;
#(
   parameter int N_BITS = PERIPH_BITS,
   parameter int N_DOMAINS = PERIPH_DOMAINS
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Watched ports
   input wire logic system_reset_request_bit,
   input wire logic brownout_reset_select,
   input wire logic brownout_flag,
   input wire logic regulator_reset_enable,
   input wire logic [PERIPH_REGS*N_BITS-1:0] peripheral_reset_control,
   input wire logic [1:0] oscillator_source_select,
   input wire logic pll_skip,
   input wire logic [CAUSE_WIDTH-1:0] reset_cause_register,
   input wire logic system_reset_n,
   input wire logic [N_DOMAINS-1:0][PERIPH_REGS*N_BITS-1:0] peripheral_reset,
   input wire logic [1:0] boot_fetch_stage,
   input wire logic boot_fetch_valid,
   input wire logic [1:0] system_clock_source
);
   // ====================
   // Checks
   // One clock domain: clocking and reset guard declared once.
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   // The three fetch steps that follow every release of the internal reset.
   sequence boot_seq;
      boot_fetch_valid && boot_fetch_stage == 2'h0 ##1 boot_fetch_valid && boot_fetch_stage == 2'h1
         ##1 boot_fetch_valid && boot_fetch_stage == 2'h2;
   endsequence

   a_sw_req_reset: assert property (system_reset_request_bit |=>
      !system_reset_n && reset_cause_register[CAUSE_SOFTWARE]) else $error("request without reset");
   a_boot_fetch: assert property ($rose(system_reset_n) |-> boot_seq)
      else $error("boot fetch order wrong");
   a_hold_periph: assert property (!system_reset_n |-> &peripheral_reset)
      else $error("peripheral free in reset");
   a_domains_match: assert property (peripheral_reset[0] == peripheral_reset[N_DOMAINS-1])
      else $error("clock domains of a unit differ");
   a_periph_follow: assert property (
      system_reset_n [*3] |-> peripheral_reset[0] == $past(peripheral_reset_control))
      else $error("peripheral reset wrong");
   a_clk_follow: assert property (
      system_reset_n [*3] |-> system_clock_source == ($past(pll_skip) ? $past(oscillator_source_select) : 2'h3))
      else $error("clock source wrong");
   a_bo_select: assert property (brownout_reset_select && $rose(brownout_flag) |-> ##[1:3] !system_reset_n)
      else $error("selected brownout gave no reset");
   a_defaults_held: assert property (
      !system_reset_n |-> !brownout_reset_select && !regulator_reset_enable && pll_skip)
      else $error("config not default in reset");
endmodule

// Attach the checks to every controller instance.
bind srcsc_top srcsc_properties #(.N_BITS(N_BITS), .N_DOMAINS(N_DOMAINS)) u_props (.*);

/* bench/tb_top.sv */
// Self-checking bench for the reset and clock source controller.
// Assumes package, design and checker compile first.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
   $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module tb_top
   import srcsc_pkg::*;
();
   // ====================
   // Design signals
   logic clk = 1'b0;
   logic reset_n, ext_reset_n, brownout_detect, regulator_unregulated, pbc_write, pbc_reset_select;
   logic pbc_resample_wait, rpc_write, rpc_reset_enable, prc_write, clk_cfg_write, clk_cfg_pll_skip;
   logic system_reset_request_bit, cause_clear_write, watchdog_enable, watchdog_reset_enable;
   logic watchdog_int_clear, brownout_reset_select, brownout_resample_wait, regulator_reset_enable;
   logic pll_skip, regulator_reset_status, brownout_flag, brownout_irq, watchdog_irq, system_reset_n;
   logic boot_fetch_valid, pll_enable;
   logic [DELAY_WIDTH-1:0] pbc_resample_delay, brownout_resample_delay;
   logic [ADJ_WIDTH-1:0] rpc_voltage_adjust, regulator_voltage_adjust;
   logic [1:0] prc_index, clk_cfg_osc_source, oscillator_source_select, boot_fetch_stage;
   logic [1:0] system_clock_source, pll_reference_source;
   logic [PERIPH_BITS-1:0] prc_data;
   logic [CAUSE_WIDTH-1:0] cause_clear_mask, reset_cause_register;
   logic [WD_WIDTH-1:0] watchdog_reload_value;
   logic [PERIPH_REGS*PERIPH_BITS-1:0] peripheral_reset_control;
   logic [PERIPH_DOMAINS-1:0][PERIPH_REGS*PERIPH_BITS-1:0] peripheral_reset;
   int n_fail = 0;
   int tests_run = 0;

   // Short holds keep the run brief.
   srcsc_top #(.BO_HOLD_CYCLES(64), .RST_HOLD_CYCLES(4)) u_dut (.*);

   // 100 MHz clock.
   always #5 clk = ~clk;

   // ====================
   // Helpers
   task automatic cyc(input int n);
      repeat (n) @(negedge clk);
   endtask

   // One-cycle write strobe, then two settling cycles.
   task automatic strobe(ref logic w);
      w = 1'b1;
      cyc(1);
      w = 1'b0;
      cyc(2);
   endtask

   // Bounded wait for the internal reset level; a release also waits out the boot fetch.
   task automatic wait_rst(input logic v);
      int i;
      i = 0;
      while (system_reset_n !== v && i < 80)
      begin
         cyc(1);
         i++;
      end
      `CHK("system_reset_n", v, system_reset_n)
      if (v)
         cyc(4);
   endtask

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // ====================
   // Scenarios
   // Every source code, the refused code 3, then the PLL path.
   task automatic t_clock;
      for (int c = 0; c < 4; c++)
      begin
         clk_cfg_osc_source = c[1:0];
         strobe(clk_cfg_write);
         `CHK("clk_src", (c == 3) ? 2'h2 : c[1:0], system_clock_source)
      end
      {clk_cfg_osc_source, clk_cfg_pll_skip} = 3'b000;
      strobe(clk_cfg_write);
      `CHK("pll_path", 5'b11001, {system_clock_source, pll_reference_source, pll_enable})
   endtask

   // Set, check every domain, then clear a peripheral reset word.
   task automatic t_periph;
      {prc_index, prc_data} = {2'h1, 32'h0000_0081};
      strobe(prc_write);
      `CHK("periph", {2{32'h0, 32'h81, 32'h0}}, peripheral_reset)
      prc_data = 32'h0;
      strobe(prc_write);
      `CHK("periph_clr", '0, {peripheral_reset, peripheral_reset_control})
   endtask

   // One brownout: config bits, detect length, expected interrupt and reset.
   task automatic bo_run(input logic sel, wt, input int len, input logic ei, er);
      logic irq_seen, rst_seen;
      int n;
      {pbc_reset_select, pbc_resample_wait, pbc_resample_delay} = {sel, wt, 8'h05};
      strobe(pbc_write);
      {irq_seen, rst_seen, n} = '0;
      brownout_detect = 1'b1;
      for (int i = 0; i < 120; i++)
      begin
         if (i == len)
            brownout_detect = 1'b0;
         cyc(1);
         irq_seen |= (brownout_irq === 1'b1);
         rst_seen |= (system_reset_n === 1'b0);
         n += (brownout_flag === 1'b1);
      end
      `CHK("bo_irq", ei, irq_seen)
      `CHK("bo_reset", er, rst_seen)
      if (len > 2)
         `CHK("bo_flag_len", 64, n)
      if (er)
         `CHK("bo_cause", 1'b1, reset_cause_register[CAUSE_BROWNOUT])
   endtask

   // Regulator loss of regulation with its reset enabled.
   task automatic t_reg;
      {rpc_reset_enable, rpc_voltage_adjust} = {1'b1, 6'h2a};
      strobe(rpc_write);
      `CHK("volt_adj", 7'h6a, {regulator_reset_enable, regulator_voltage_adjust})
      regulator_unregulated = 1'b1;
      wait_rst(1'b0);
      `CHK("reg_status", 1'b1, regulator_reset_status)
      regulator_unregulated = 1'b0;
      wait_rst(1'b1);
      `CHK("reg_en_dflt", 1'b0, regulator_reset_enable)
   endtask

   // Watchdog: first time-out interrupts, serviced runs on, unserviced resets.
   task automatic t_wd;
      {watchdog_reset_enable, watchdog_enable} = 2'b11;
      cyc(21);
      `CHK("wd_irq", 1'b1, watchdog_irq)
      watchdog_int_clear = 1'b1;
      cyc(60);
      `CHK("wd_serviced", 1'b1, system_reset_n)
      watchdog_int_clear = 1'b0;
      wait_rst(1'b0);
      watchdog_enable = 1'b0;
      `CHK("wd_cause", 1'b1, reset_cause_register[CAUSE_WATCHDOG])
      wait_rst(1'b1);
   endtask

   // Main sequence; power-on reset held five cycles.
   initial
   begin
      {reset_n, ext_reset_n, brownout_detect, regulator_unregulated, pbc_write, pbc_reset_select} = 6'h10;
      {pbc_resample_wait, rpc_write, rpc_reset_enable, prc_write, clk_cfg_write, clk_cfg_pll_skip} = 6'h01;
      {system_reset_request_bit, cause_clear_write, watchdog_enable, watchdog_reset_enable} = '0;
      {watchdog_int_clear, pbc_resample_delay, rpc_voltage_adjust, prc_index, clk_cfg_osc_source} = '0;
      {prc_data, cause_clear_mask, watchdog_reload_value} = {32'h0, 6'h08, 32'd20};
      cyc(5);
      `CHK("por_cause", CAUSE_POWER_ON_VALUE, reset_cause_register)
      reset_n = 1'b1;
      wait_rst(1'b1);
      t_clock();
      t_periph();
      strobe(system_reset_request_bit);
      `CHK("sw_reset", 2'b01, {system_reset_n, reset_cause_register[CAUSE_SOFTWARE]})
      wait_rst(1'b1);
      strobe(cause_clear_write);
      `CHK("cause_clr", 1'b0, reset_cause_register[CAUSE_SOFTWARE])
      bo_run(1'b0, 1'b0, 30, 1'b1, 1'b0);
      bo_run(1'b0, 1'b1, 1, 1'b0, 1'b0);
      bo_run(1'b0, 1'b1, 30, 1'b1, 1'b0);
      bo_run(1'b1, 1'b0, 30, 1'b0, 1'b1);
      `CHK("bo_sel_dflt", 10'h0, {brownout_reset_select, brownout_resample_wait, brownout_resample_delay})
      t_reg();
      t_wd();
      ext_reset_n = 1'b0;
      cyc(6);
      `CHK("ext_cause", 6'h01, reset_cause_register)
      ext_reset_n = 1'b1;
      wait_rst(1'b1);
      stop_test();
   end

   // Hang guard, well beyond the run's length.
   initial
   begin
      #100us;
      n_fail++;
      stop_test();
   end
endmodule

/* src/srcsc_brownout.sv */
// Brownout condition flag with resample filter and timed self-clear.
// Assumes detect is already synchronised to clk.
`timescale 1ns/1ps
module srcsc_brownout
   import srcsc_pkg::*;
#(
   parameter int HOLD_CYCLES = BROWNOUT_HOLD_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Condition and configuration
   input wire logic detect,
   input wire logic reset_select,
   input wire logic resample_wait,
   input wire logic [DELAY_WIDTH-1:0] resample_delay,
   // Results
   output logic flag,
   output logic irq,
   output logic reset_req
);

   localparam int HW = $clog2(HOLD_CYCLES + 1);
   typedef enum logic [1:0] {ST_IDLE, ST_RESAMPLE, ST_HOLD} srcsc_bo_state_type;
   srcsc_bo_state_type state;
   logic [HW-1:0] hold_cnt;
   logic [DELAY_WIDTH-1:0] wait_cnt;

   // ====================
   // Sequence; not reset by the internal system reset so the flag survives it.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state <= ST_IDLE;
         flag <= 1'b0;
         irq <= 1'b0;
         reset_req <= 1'b0;
         hold_cnt <= '0;
         wait_cnt <= '0;
      end
      else
      begin
         irq <= 1'b0;
         reset_req <= 1'b0;
         if (state != ST_IDLE)
            hold_cnt <= hold_cnt - 1'b1;
         case (state)
            ST_IDLE:
               if (detect)
               begin
                  flag <= 1'b1;
                  hold_cnt <= HW'(HOLD_CYCLES - 1);
                  if (reset_select)
                  begin
                     reset_req <= 1'b1;
                     state <= ST_HOLD;
                  end
                  else if (resample_wait)
                  begin
                     wait_cnt <= resample_delay;
                     state <= ST_RESAMPLE;
                  end
                  else
                  begin
                     irq <= 1'b1;
                     state <= ST_HOLD;
                  end
               end
            ST_RESAMPLE:
               if (wait_cnt != '0)
                  wait_cnt <= wait_cnt - 1'b1;
               else if (detect)
               begin
                  irq <= !reset_select;
                  reset_req <= reset_select;
                  state <= ST_HOLD;
               end
               else
               begin
                  flag <= 1'b0;
                  state <= ST_IDLE;
               end
            ST_HOLD:
               if (hold_cnt == '0)
               begin
                  flag <= 1'b0;
                  state <= ST_IDLE;
               end
            default:
               state <= ST_IDLE;
         endcase
      end
   end

endmodule

/* src/srcsc_pkg.sv */
// Shared constants for the system reset and clock source controller.
// Assumes one system clock at 100 MHz and a synchronous active-low reset.
package srcsc_pkg;

   // ====================
   // Timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int BROWNOUT_HOLD_US = 500;
   localparam int BROWNOUT_HOLD_CYCLES = BROWNOUT_HOLD_US * 1000 / CLK_PERIOD_NS;
   localparam int SYSRST_HOLD_CYCLES = 16;

   // ====================
   // Widths
   localparam int WD_WIDTH = 32;
   localparam int PERIPH_REGS = 3;
   localparam int PERIPH_BITS = 32;
   localparam int PERIPH_DOMAINS = 2;
   localparam int DELAY_WIDTH = 8;
   localparam int ADJ_WIDTH = 6;
   localparam int CAUSE_WIDTH = 6;

   // ====================
   // Oscillator source and system clock source codes
   localparam logic [1:0] OSC_SRC_MAIN = 2'h0;
   localparam logic [1:0] OSC_SRC_INTERNAL = 2'h1;
   localparam logic [1:0] OSC_SRC_INTERNAL_DIV4 = 2'h2;
   localparam logic [1:0] SYSTEM_CLOCK_FROM_PLL = 2'h3;

   // ====================
   // Reset cause bit positions
   localparam int CAUSE_EXT = 0;
   localparam int CAUSE_POWER_ON = 1;
   localparam int CAUSE_BROWNOUT = 2;
   localparam int CAUSE_SOFTWARE = 3;
   localparam int CAUSE_WATCHDOG = 4;
   localparam int CAUSE_REGULATOR = 5;

   // ====================
   // Reset values
   localparam logic [CAUSE_WIDTH-1:0] CAUSE_POWER_ON_VALUE = 6'h02;
   localparam logic [1:0] OSC_SRC_RESET = OSC_SRC_MAIN;
   localparam logic PLL_SKIP_RESET = 1'b1;
   localparam logic [ADJ_WIDTH-1:0] ADJ_RESET = 6'h00;
   localparam logic [DELAY_WIDTH-1:0] DELAY_RESET = 8'h00;

endpackage

/* src/srcsc_top.sv */
// System reset and clock source controller: gathers reset sources into one
// internal system reset, sequences the boot fetch, holds peripheral resets,
// regulator adjust and system clock source selection.
// Assumes one 100 MHz clock; pins brownout_detect, regulator_unregulated and
// ext_reset_n are synchronised here.
`timescale 1ns/1ps

// How it works
// - Brownout reset select clears at reset; software sets it by write.
// - A brownout raises an interrupt pulse or a system reset.
// - Brownout resets the system only while reset select is set.
// - With wait set and select clear, resample after delay; absent means nothing.
// - The resample filter guards the interrupt path, enabled by software.
// - Persistent brownout asserts internal reset, then releases into boot fetch.
// - Brownout flag clears itself 500 us after being set.
// - Peripheral reset bit set holds reset; clearing it releases.
// - Peripheral reset bit order equals the clock-gating bit order.
// - A peripheral reset drives every clock-domain reset of that unit.
// - System reset request resets all but the cause bits and brownout flag, including core, then boots.
// - Watchdog interrupts on first time-out, requests reset on second.
// - Watchdog reloads after time-out; zero again unserviced resets if enabled.
// - Regulator reset enable clears at reset; software sets it.
// - Unregulated regulator sets status bit and resets, then boots.
// - Voltage adjust field sets regulated output in 2.25 to 2.75 V steps.
// - System clock comes from main, internal, internal/4 or PLL.
// - Source codes: main 0x0, internal 0x1, internal/4 0x2.
// - PLL skip set: oscillator drives clock; clear: oscillator feeds PLL.
// - Cause bits stick across resets; external pin reset clears the others.
module srcsc_top
   import srcsc_pkg::*;
#(
   parameter int N_BITS = PERIPH_BITS,
   parameter int N_DOMAINS = PERIPH_DOMAINS,
   parameter int BO_HOLD_CYCLES = BROWNOUT_HOLD_CYCLES,
   parameter int RST_HOLD_CYCLES = SYSRST_HOLD_CYCLES
)
(
   // Clock and power-on reset
   input wire logic clk,
   input wire logic reset_n,
   // Asynchronous pins
   input wire logic ext_reset_n,
   input wire logic brownout_detect,
   input wire logic regulator_unregulated,
   // Power and brownout control write
   input wire logic pbc_write,
   input wire logic pbc_reset_select,
   input wire logic pbc_resample_wait,
   input wire logic [DELAY_WIDTH-1:0] pbc_resample_delay,
   // Regulator power control write
   input wire logic rpc_write,
   input wire logic rpc_reset_enable,
   input wire logic [ADJ_WIDTH-1:0] rpc_voltage_adjust,
   // Peripheral reset control write
   input wire logic prc_write,
   input wire logic [1:0] prc_index,
   input wire logic [N_BITS-1:0] prc_data,
   // Clock source write
   input wire logic clk_cfg_write,
   input wire logic [1:0] clk_cfg_osc_source,
   input wire logic clk_cfg_pll_skip,
   // Processor system reset request and cause clear
   input wire logic system_reset_request_bit,
   input wire logic cause_clear_write,
   input wire logic [CAUSE_WIDTH-1:0] cause_clear_mask,
   // Watchdog control
   input wire logic watchdog_enable,
   input wire logic watchdog_reset_enable,
   input wire logic watchdog_int_clear,
   input wire logic [WD_WIDTH-1:0] watchdog_reload_value,
   // Control readback
   output logic brownout_reset_select,
   output logic brownout_resample_wait,
   output logic [DELAY_WIDTH-1:0] brownout_resample_delay,
   output logic regulator_reset_enable,
   output logic [ADJ_WIDTH-1:0] regulator_voltage_adjust,
   output logic [PERIPH_REGS*N_BITS-1:0] peripheral_reset_control,
   output logic [1:0] oscillator_source_select,
   output logic pll_skip,
   // Status
   output logic [CAUSE_WIDTH-1:0] reset_cause_register,
   output logic regulator_reset_status,
   output logic brownout_flag,
   output logic brownout_irq,
   output logic watchdog_irq,
   // Resets and boot
   output logic system_reset_n,
   output logic [N_DOMAINS-1:0][PERIPH_REGS*N_BITS-1:0] peripheral_reset,
   output logic [1:0] boot_fetch_stage,
   output logic boot_fetch_valid,
   // Clock selection
   output logic [1:0] system_clock_source,
   output logic [1:0] pll_reference_source,
   output logic pll_enable
);

   // ====================
   // Pin synchronisers
   // Only the second stage is read by any logic.
   logic [1:0] ext_sync;
   logic [1:0] bo_sync;
   logic [1:0] reg_sync;
   logic reg_seen;

   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         ext_sync <= 2'h3;
         bo_sync <= 2'h0;
         reg_sync <= 2'h0;
         reg_seen <= 1'b0;
      end
      else
      begin
         ext_sync <= {ext_sync[0], ext_reset_n};
         bo_sync <= {bo_sync[0], brownout_detect};
         reg_sync <= {reg_sync[0], regulator_unregulated};
         reg_seen <= reg_sync[1];
      end
   end

   // Pin reset is active while the synchronised level is low.
   wire ext_active = !ext_sync[1];
   wire reg_rise = reg_sync[1] && !reg_seen;

   // ====================
   // Reset sequencer state
   typedef enum logic [2:0] {SEQ_HOLD, SEQ_FETCH_SP, SEQ_FETCH_PC, SEQ_FETCH_INSN, SEQ_RUN} srcsc_seq_type;
   localparam int HOLD_W = $clog2(RST_HOLD_CYCLES + 1);
   srcsc_seq_type state;
   srcsc_seq_type next_state;
   logic [HOLD_W-1:0] hold_cnt;
   wire in_hold = (state == SEQ_HOLD);
   wire enter_hold = (next_state == SEQ_HOLD);
   // Configuration returns to defaults under power-on reset and internal reset.
   wire cfg_clear = !reset_n || enter_hold;

   // ====================
   // Reset source requests
   logic bo_reset_req;
   logic bo_irq;
   logic bo_flag;
   srcsc_wd_if #(.WIDTH(WD_WIDTH)) wd_link ();

   wire reg_req = reg_rise && regulator_reset_enable;
   wire sw_req = system_reset_request_bit;
   wire wd_req = wd_link.reset_req;
   wire any_req = bo_reset_req || sw_req || wd_req || reg_req || ext_active;

   // Each internal source marks its own cause bit in the cycle it fires.
   wire [CAUSE_WIDTH-1:0] cause_set = (CAUSE_WIDTH'(bo_reset_req) << CAUSE_BROWNOUT)
                                    | (CAUSE_WIDTH'(sw_req) << CAUSE_SOFTWARE)
                                    | (CAUSE_WIDTH'(wd_req) << CAUSE_WATCHDOG)
                                    | (CAUSE_WIDTH'(reg_req) << CAUSE_REGULATOR);
   wire [CAUSE_WIDTH-1:0] cause_clr = cause_clear_write ? cause_clear_mask : '0;

   // ====================
   // Brownout and watchdog
   srcsc_brownout #(.HOLD_CYCLES(BO_HOLD_CYCLES)) u_brownout
   (
      .clk(clk),
      .reset_n(reset_n),
      .detect(bo_sync[1]),
      .reset_select(brownout_reset_select),
      .resample_wait(brownout_resample_wait),
      .resample_delay(brownout_resample_delay),
      .flag(bo_flag),
      .irq(bo_irq),
      .reset_req(bo_reset_req)
   );

   assign wd_link.enable = watchdog_enable;
   assign wd_link.reset_enable = watchdog_reset_enable;
   assign wd_link.int_clear = watchdog_int_clear;
   assign wd_link.reload = watchdog_reload_value;

   srcsc_watchdog u_watchdog
   (
      .clk(clk),
      .reset_n(reset_n),
      .sys_hold(in_hold),
      .wd(wd_link)
   );

   assign brownout_flag = bo_flag;
   assign brownout_irq = bo_irq;
   assign watchdog_irq = wd_link.irq;

   // ====================
   // Sequencer next state
   // Any request restarts the hold, even part way through a boot fetch.
   always_comb
   begin
      next_state = state;
      case (state)
         SEQ_HOLD:
            if (hold_cnt == '0 && !ext_active)
               next_state = SEQ_FETCH_SP;
         SEQ_FETCH_SP:
            next_state = SEQ_FETCH_PC;
         SEQ_FETCH_PC:
            next_state = SEQ_FETCH_INSN;
         SEQ_FETCH_INSN:
            next_state = SEQ_RUN;
         SEQ_RUN:
            next_state = SEQ_RUN;
         default:
            next_state = SEQ_HOLD;
      endcase
      if (any_req)
         next_state = SEQ_HOLD;
   end

   // Sequencer registers; outputs are taken from the next state so they
   // line up with the state register.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         state <= SEQ_HOLD;
         hold_cnt <= HOLD_W'(RST_HOLD_CYCLES - 1);
         system_reset_n <= 1'b0;
         boot_fetch_valid <= 1'b0;
         boot_fetch_stage <= 2'h0;
      end
      else
      begin
         state <= next_state;
         if (any_req)
            hold_cnt <= HOLD_W'(RST_HOLD_CYCLES - 1);
         else if (in_hold && hold_cnt != '0)
            hold_cnt <= hold_cnt - 1'b1;
         system_reset_n <= (next_state != SEQ_HOLD);
         boot_fetch_valid <= (next_state == SEQ_FETCH_SP) || (next_state == SEQ_FETCH_PC)
                             || (next_state == SEQ_FETCH_INSN);
         boot_fetch_stage <= (next_state == SEQ_FETCH_PC) ? 2'h1 :
                             (next_state == SEQ_FETCH_INSN) ? 2'h2 : 2'h0;
      end
   end

   // ====================
   // Reset cause register
   // Power-on sets only its own bit; a pin reset keeps only its own bit.
   // A source firing in the same cycle as a software clear keeps its bit.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
         reset_cause_register <= CAUSE_POWER_ON_VALUE;
      else if (ext_active)
         reset_cause_register <= CAUSE_WIDTH'(1) << CAUSE_EXT;
      else
         reset_cause_register <= (reset_cause_register & ~cause_clr) | cause_set;
   end

   assign regulator_reset_status = reset_cause_register[CAUSE_REGULATOR];

   // ====================
   // Power, brownout and regulator control
   // Both reset enables come up clear so a noisy supply at start-up
   // cannot loop the part through resets before software decides.
   always_ff @(posedge clk)
   begin
      if (cfg_clear)
      begin
         brownout_reset_select <= 1'b0;
         brownout_resample_wait <= 1'b0;
         brownout_resample_delay <= DELAY_RESET;
         regulator_reset_enable <= 1'b0;
         regulator_voltage_adjust <= ADJ_RESET;
      end
      else
      begin
         if (pbc_write)
         begin
            brownout_reset_select <= pbc_reset_select;
            brownout_resample_wait <= pbc_resample_wait;
            brownout_resample_delay <= pbc_resample_delay;
         end
         if (rpc_write)
         begin
            regulator_reset_enable <= rpc_reset_enable;
            regulator_voltage_adjust <= rpc_voltage_adjust;
         end
      end
   end

   // ====================
   // Peripheral reset control
   // Bit n of each word is the same unit as bit n of the clock-gating words.
   genvar r;
   genvar d;
   generate
      for (r = 0; r < PERIPH_REGS; r = r + 1)
      begin : g_prc
         wire hit = prc_write && (prc_index == 2'(r));
         always_ff @(posedge clk)
         begin
            if (cfg_clear)
               peripheral_reset_control[r*N_BITS +: N_BITS] <= '0;
            else if (hit)
               peripheral_reset_control[r*N_BITS +: N_BITS] <= prc_data;
         end
      end
      // Every clock domain of a unit sees the same reset; the system
      // reset also holds all of them.
      for (d = 0; d < N_DOMAINS; d = d + 1)
      begin : g_dom
         always_ff @(posedge clk)
         begin
            if (!reset_n)
               peripheral_reset[d] <= '1;
            else
               peripheral_reset[d] <= peripheral_reset_control | {(PERIPH_REGS*N_BITS){enter_hold}};
         end
      end
   endgenerate

   // ====================
   // Clock source selection
   // The reserved source code is refused and the old source stays, so a
   // bad write cannot stop the system clock.
   wire src_ok = (clk_cfg_osc_source != SYSTEM_CLOCK_FROM_PLL);

   always_ff @(posedge clk)
   begin
      if (cfg_clear)
      begin
         oscillator_source_select <= OSC_SRC_RESET;
         pll_skip <= PLL_SKIP_RESET;
      end
      else if (clk_cfg_write)
      begin
         if (src_ok)
            oscillator_source_select <= clk_cfg_osc_source;
         pll_skip <= clk_cfg_pll_skip;
      end
   end

   // With the PLL in use the chosen oscillator becomes its reference.
   // Keeping that reference in the PLL's range is software's job.
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         system_clock_source <= OSC_SRC_RESET;
         pll_reference_source <= OSC_SRC_RESET;
         pll_enable <= !PLL_SKIP_RESET;
      end
      else
      begin
         system_clock_source <= pll_skip ? oscillator_source_select : SYSTEM_CLOCK_FROM_PLL;
         pll_reference_source <= oscillator_source_select;
         pll_enable <= !pll_skip;
      end
   end

endmodule

/* src/srcsc_watchdog.sv */
// Watchdog down-counter: interrupt on first time-out, reset request on second.
// Assumes sys_hold is the controller's internal system reset, active high.
`timescale 1ns/1ps
module srcsc_watchdog
   import srcsc_pkg::*;
(
   // Clock and resets
   input wire logic clk,
   input wire logic reset_n,
   input wire logic sys_hold,
   // Controller link
   srcsc_wd_if.timer wd
);

   // ====================
   // Counter
   logic [WD_WIDTH-1:0] count;
   logic irq;
   logic reset_req;
   wire at_zero = (count == '0);
   wire [WD_WIDTH-1:0] next_count = at_zero ? wd.reload : count - 1'b1;
   // A clear in the time-out cycle counts as serviced.
   wire next_fire = wd.enable && at_zero && irq && !wd.int_clear && wd.reset_enable;

   // Disabled, the counter sits at the reload value; zero reloads and counts on.
   always_ff @(posedge clk)
   begin
      if (!reset_n || sys_hold)
      begin
         count <= '0;
         irq <= 1'b0;
         reset_req <= 1'b0;
      end
      else
      begin
         count <= wd.enable ? next_count : wd.reload;
         irq <= (irq && !wd.int_clear) || (wd.enable && at_zero);
         reset_req <= next_fire;
      end
   end

   assign wd.irq = irq;
   assign wd.reset_req = reset_req;

endmodule

/* src/srcsc_wd_if.sv */
// Link between the controller and its watchdog timer.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface srcsc_wd_if #(parameter int WIDTH = 32);
   logic enable;
   logic reset_enable;
   logic int_clear;
   logic [WIDTH-1:0] reload;
   logic irq;
   logic reset_req;
   modport ctrl (output enable, output reset_enable, output int_clear, output reload, input irq, input reset_req);
   modport timer (input enable, input reset_enable, input int_clear, input reload, output irq, output reset_req);
endinterface
